// File: msi_indexer.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - each coil shows a table position and a polarity bit
// - coil A expected current is sin(90 deg * position / 255)
// - polarity 1 means positive current, 0 negative, both coils
// - quadrant ramps of A and B positions and polarities follow the indexer table
// - open-drain home pin pulled low only in the 45 degree state
// - home status bit reads 0 whenever the indexer is home
// - home pin pulses low once per electrical turn, every four full steps
// - interpolation starts only when its enable bit is set, a started interval runs on to its target after a clear
// - resolution field 00/01/10/11 selects 1/256, 1/128, 1/64, 1/32
// - previous step interval split into equal sub-steps
// - late step edge: stop interpolating and hold position
// - standstill saving after delay without edge, left on next edge
// - early step edge jumps to demanded position, new rate follows
// - toggling interpolation while stepping causes no position jump
// - custom enable selects the programmed profile over the sine
// - eight points from 11.25 to 90 degrees, zero at 0 degrees
// - points expanded piecewise linearly to 256 entries at 1/256
// - first quadrant mirrored to other quadrants and to coil B
// - after reset indexer starts at 45 degrees, 71 percent both coils
// - rising or both step edges active, low direction reverses
module msi_indexer #(
    parameter int unsigned               CNT_W       = msi_pkg::CNT_W,
    parameter logic [CNT_W-1:0]          STSL_CYCLES = CNT_W'(msi_pkg::STSL_DELAY_CYCLES)
) (
    // clock and reset
    input  wire logic                          REF_CLK,
    input  wire logic                          NRST,
    // apb slave
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [msi_pkg::ADDR_W-1:0]    PADDR,
    input  wire logic [msi_pkg::DATA_W-1:0]    PWDATA,
    output var  logic [msi_pkg::DATA_W-1:0]    PRDATA,
    output var  logic                          PREADY,
    output var  logic                          PSLVERR,
    // step and direction pins
    input  wire logic                          STEP,
    input  wire logic                          DIR,
    // open-drain home pin
    output var  logic                          HOME_INDICATOR_LOW_O,
    output var  logic                          HOME_INDICATOR_LOW_OE,
    // indexer outputs
    output var  logic [7:0]                    COIL_A_TABLE_POSITION,
    output var  logic                          COIL_A_POLARITY,
    output var  logic [7:0]                    COIL_B_TABLE_POSITION,
    output var  logic                          COIL_B_POLARITY,
    output var  logic [7:0]                    COIL_A_EXPECTED_CURRENT,
    output var  logic                          STANDSTILL_SAVE
);
    import msi_pkg::*;

    localparam int ACC_W = CNT_W + 1;

    // piecewise-linear lookup over nine points, shared by both coils
    function automatic logic [7:0] profile_lookup(input logic [8:0][7:0] pts,
                                                  input logic [7:0]      idx);
        logic [3:0]         seg;
        logic signed [9:0]  lo;
        logic signed [9:0]  hi;
        logic signed [15:0] diff;
        logic signed [15:0] val;
        seg  = {1'b0, idx[7:5]};
        lo   = signed'({2'b00, pts[seg]});
        hi   = signed'({2'b00, pts[seg + 4'd1]});
        diff = 16'(hi - lo) * signed'({11'h000, idx[4:0]});
        val  = 16'(lo) + (diff >>> 5);
        profile_lookup = (idx == IDX_LAST) ? pts[8] : val[7:0];
    endfunction : profile_lookup

    // synchronised pins: bit 0 step, bit 1 direction
    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;

    msi_pin_sync #(.WIDTH(2)) u_sync (
        .clk      (REF_CLK),
        .nrst     (NRST),
        .async_in ({DIR, STEP}),
        .level    (pin_level),
        .rise     (pin_rise),
        .fall     (pin_fall)
    );

    // control and profile registers
    logic             interp_en_q;
    logic [1:0]       res_q;
    logic             stsl_en_q;
    logic             custom_en_q;
    logic             edge_both_q;
    logic [3:0]       mode_q;
    logic [7:0]       prof_q [NUM_POINTS];

    // indexer state
    logic [PHASE_W-1:0] pos_q;
    logic [PHASE_W-1:0] target_q;
    logic [PHASE_W-1:0] sub_q;
    logic [PHASE_W-1:0] nsub_q;
    logic [PHASE_W-1:0] rem_q;
    logic               dir_seg_q;
    logic [1:0]         seen_q;
    logic [CNT_W-1:0]   cnt_q;
    logic [CNT_W-1:0]   period_q;
    logic [ACC_W-1:0]   acc_q;
    logic               stsl_q;
    logic               pready_q;

    // step edge selection and step sizes
    logic               step_evt;
    logic               dir_lvl;
    logic [PHASE_W-1:0] inc;
    logic [PHASE_W-1:0] sub;
    logic [PHASE_W-1:0] nsub;
    logic [PHASE_W-1:0] tgt_next;
    logic               interp_go;
    assign dir_lvl   = pin_level[1];
    assign step_evt  = pin_rise[0] | (edge_both_q & pin_fall[0]);
    assign inc       = PHASE_W'(1) << (MODE_FINEST - mode_q);
    assign sub       = PHASE_W'(1) << res_q;
    assign nsub      = inc >> res_q;
    assign tgt_next  = dir_lvl ? target_q + inc : target_q - inc;
    assign interp_go = interp_en_q & (seen_q != 2'b00) & (nsub != '0);

    // sub-step pacing: nsub sub-steps spread evenly over one interval
    logic [ACC_W-1:0]   acc_sum;
    logic               sub_due;
    logic [PHASE_W-1:0] pos_step;
    assign acc_sum  = acc_q + ACC_W'(nsub_q);
    assign sub_due  = (rem_q != '0) & (acc_sum >= {1'b0, period_q});
    assign pos_step = dir_seg_q ? pos_q + sub_q : pos_q - sub_q;

    // table position, polarity and current from the phase
    logic [1:0]       quad;
    logic [7:0]       a_pos;
    logic [7:0]       b_pos;
    logic             a_sign;
    logic             b_sign;
    logic [8:0][7:0]  pts;
    logic [7:0]       a_cur;
    logic             at_home;
    assign quad    = pos_q[9:8];
    assign a_pos   = quad[0] ? ~pos_q[7:0] : pos_q[7:0];
    assign b_pos   = ~a_pos;
    assign a_sign  = ~quad[1];
    assign b_sign  = ~(quad[1] ^ quad[0]);
    assign pts[0]  = 8'h00;
    generate
        for (genvar k = 0; k < NUM_POINTS; k++) begin : g_pts
            assign pts[k+1] = custom_en_q ? prof_q[k] : SINE_POINTS[k];
        end
    endgenerate
    assign a_cur   = profile_lookup(pts, a_pos);
    assign at_home = (pos_q == HOME_PHASE);

    // apb decode
    logic        aligned;
    logic        hit_ctrl;
    logic        hit_status;
    logic        hit_position;
    logic        hit_current;
    logic        hit_prof;
    logic        hit_any;
    logic [2:0]  prof_idx;
    logic        pready_d;
    logic        apb_wr;
    logic [DATA_W-1:0] rd_ctrl;
    logic [DATA_W-1:0] rd_status;
    logic [DATA_W-1:0] rd_position;
    logic [DATA_W-1:0] rd_current;
    logic [DATA_W-1:0] rdata_mux;
    assign aligned      = (PADDR[1:0] == 2'b00);
    assign hit_ctrl     = (PADDR == ADDR_CTRL);
    assign hit_status   = (PADDR == ADDR_STATUS);
    assign hit_position = (PADDR == ADDR_POSITION);
    assign hit_current  = (PADDR == ADDR_CURRENT);
    assign hit_prof     = aligned & (PADDR[ADDR_W-1:5] == ADDR_PROF_BASE[ADDR_W-1:5]);
    assign hit_any      = hit_ctrl | hit_status | hit_position | hit_current | hit_prof;
    assign prof_idx     = PADDR[4:2];
    assign pready_d     = PSEL & PENABLE & ~pready_q;
    assign apb_wr       = PSEL & PENABLE & PWRITE & pready_q;
    assign rd_ctrl      = DATA_W'({mode_q, edge_both_q, custom_en_q, stsl_en_q,
                                   res_q, interp_en_q});
    assign rd_status    = DATA_W'({dir_lvl, stsl_q, ~HOME_INDICATOR_LOW_OE});
    assign rd_position  = (DATA_W'(COIL_A_TABLE_POSITION) << POS_A_LSB)
                        | (DATA_W'(COIL_A_POLARITY) << POS_A_SIGN_BIT)
                        | (DATA_W'(COIL_B_TABLE_POSITION) << POS_B_LSB)
                        | (DATA_W'(COIL_B_POLARITY) << POS_B_SIGN_BIT);
    assign rd_current   = (DATA_W'(COIL_A_EXPECTED_CURRENT) << COIL_A_EXPECTED_CURRENT_LSB)
                        | (DATA_W'(profile_lookup(pts, COIL_B_TABLE_POSITION)) << CUR_B_LSB);
    assign rdata_mux    = hit_ctrl     ? rd_ctrl     :
                          hit_status   ? rd_status   :
                          hit_position ? rd_position :
                          hit_current  ? rd_current  :
                          hit_prof     ? DATA_W'(prof_q[prof_idx]) : 32'h0000_0000;

    // apb answer: ready one cycle into the access phase
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            pready_q <= 1'b0;
            PRDATA   <= 32'h0000_0000;
            PSLVERR  <= 1'b0;
        end else begin
            pready_q <= pready_d;
            PSLVERR  <= pready_d & ~hit_any;
            if (pready_d) begin
                PRDATA <= hit_any & ~PWRITE ? rdata_mux : 32'h0000_0000;
            end
        end
    end
    assign PREADY = pready_q;

    // control register writes, step mode clamped to 1/256
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            interp_en_q <= 1'b0;
            res_q       <= 2'b00;
            stsl_en_q   <= 1'b0;
            custom_en_q <= 1'b0;
            edge_both_q <= 1'b0;
            mode_q      <= MODE_RST;
        end else if (apb_wr && hit_ctrl) begin
            interp_en_q <= PWDATA[CTRL_INTERP_BIT];
            res_q       <= PWDATA[CTRL_RES_LSB +: 2];
            stsl_en_q   <= PWDATA[CTRL_STSL_BIT];
            custom_en_q <= PWDATA[CTRL_CUSTOM_BIT];
            edge_both_q <= PWDATA[CTRL_EDGE_BIT];
            mode_q      <= (PWDATA[CTRL_MODE_LSB +: 4] > MODE_FINEST) ?
                           MODE_FINEST : PWDATA[CTRL_MODE_LSB +: 4];
        end
    end

    // profile point writes, reset to the built-in sine points
    always_ff @(posedge REF_CLK) begin
        for (int k = 0; k < NUM_POINTS; k++) begin
            if (!NRST) begin
                prof_q[k] <= SINE_POINTS[k];
            end else if (apb_wr && hit_prof && (prof_idx == 3'(k))) begin
                prof_q[k] <= PWDATA[7:0];
            end
        end
    end

    // interval counter, saturating, restarts on each active edge
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            cnt_q    <= '0;
            period_q <= '0;
            seen_q   <= 2'b00;
        end else if (step_evt) begin
            cnt_q    <= '0;
            period_q <= cnt_q;
            seen_q   <= (seen_q == 2'b00) ? 2'b01 : 2'b10;
        end else if (cnt_q != '1) begin
            cnt_q    <= cnt_q + CNT_W'(1);
        end
    end

    // standstill saving: entered after the delay, left on the next edge
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            stsl_q <= 1'b0;
        end else if (step_evt || !stsl_en_q) begin
            stsl_q <= 1'b0;
        end else if (cnt_q >= STSL_CYCLES) begin
            stsl_q <= 1'b1;
        end
    end

    // indexer: jump on edge, then interpolate toward the new target
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            pos_q     <= HOME_PHASE;
            target_q  <= HOME_PHASE;
            sub_q     <= '0;
            nsub_q    <= '0;
            rem_q     <= '0;
            acc_q     <= '0;
            dir_seg_q <= 1'b1;
        end else if (step_evt) begin
            target_q  <= tgt_next;
            sub_q     <= sub;
            nsub_q    <= nsub;
            acc_q     <= '0;
            dir_seg_q <= dir_lvl;
            if (interp_go) begin
                pos_q <= target_q;
                rem_q <= nsub;
            end else begin
                pos_q <= tgt_next;
                rem_q <= '0;
            end
        end else if (rem_q != '0) begin
            // finishing after a disable keeps the motion continuous
            if (sub_due) begin
                pos_q <= pos_step;
                rem_q <= rem_q - PHASE_W'(1);
                acc_q <= acc_sum - {1'b0, period_q};
            end else begin
                acc_q <= acc_sum;
            end
        end
    end

    // registered outputs
    always_ff @(posedge REF_CLK) begin
        if (!NRST) begin
            COIL_A_TABLE_POSITION   <= HOME_PHASE[7:0];
            COIL_B_TABLE_POSITION   <= ~HOME_PHASE[7:0];
            COIL_A_POLARITY         <= 1'b1;
            COIL_B_POLARITY         <= 1'b1;
            COIL_A_EXPECTED_CURRENT <= SINE_POINTS[3];
            HOME_INDICATOR_LOW_O    <= 1'b0;
            HOME_INDICATOR_LOW_OE   <= 1'b1;
            STANDSTILL_SAVE         <= 1'b0;
        end else begin
            COIL_A_TABLE_POSITION   <= a_pos;
            COIL_B_TABLE_POSITION   <= b_pos;
            COIL_A_POLARITY         <= a_sign;
            COIL_B_POLARITY         <= b_sign;
            COIL_A_EXPECTED_CURRENT <= a_cur;
            HOME_INDICATOR_LOW_O    <= 1'b0;
            HOME_INDICATOR_LOW_OE   <= at_home;
            STANDSTILL_SAVE         <= stsl_q;
        end
    end

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!NRST);

    property p_home_pin;
        at_home |=> HOME_INDICATOR_LOW_OE;
    endproperty
    a_home_pin: assert property (p_home_pin) else $error("home pin not low at home");

    property p_home_release;
        !at_home |=> !HOME_INDICATOR_LOW_OE;
    endproperty
    a_home_release: assert property (p_home_release) else $error("home pin low off home");

    property p_home_bit;
        at_home |=> (rd_status[STAT_HOME_BIT] == 1'b0);
    endproperty
    a_home_bit: assert property (p_home_bit) else $error("home status bit not zero");

    property p_pos_mirror;
        ##1 (32'(COIL_A_TABLE_POSITION) + 32'(COIL_B_TABLE_POSITION) == 255);
    endproperty
    a_pos_mirror: assert property (p_pos_mirror) else $error("coil positions not mirrored");

    property p_sign_quad;
        ##1 (COIL_A_POLARITY == !$past(pos_q[9]))
            && (COIL_B_POLARITY == ($past(pos_q[9]) == $past(pos_q[8])));
    endproperty
    a_sign_quad: assert property (p_sign_quad) else $error("polarity wrong for quadrant");

    property p_direct_step;
        (step_evt && !interp_go) |=> (pos_q == target_q) && (rem_q == '0);
    endproperty
    a_direct_step: assert property (p_direct_step) else $error("direct step left a lag");

    property p_jump;
        (step_evt && interp_go) |=> (pos_q == $past(target_q)) && (rem_q == $past(nsub));
    endproperty
    a_jump: assert property (p_jump) else $error("edge did not jump to demanded position");

    property p_hold;
        (rem_q == '0 && !step_evt) |=> $stable(pos_q);
    endproperty
    a_hold: assert property (p_hold) else $error("position moved while holding");

    property p_stsl_exit;
        step_evt |=> !stsl_q ##1 !STANDSTILL_SAVE;
    endproperty
    a_stsl_exit: assert property (p_stsl_exit) else $error("standstill not left on edge");

    property p_sub_size;
        (sub_due && !step_evt) |=> ((pos_q - $past(pos_q)) == $past(sub_q)
                                   || ($past(pos_q) - pos_q) == $past(sub_q));
    endproperty
    a_sub_size: assert property (p_sub_size) else $error("sub-step size wrong");
endmodule : msi_indexer
`default_nettype wire

// File: msi_indexer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module msi_indexer_tb;
    import msi_pkg::*;
    // design pins
    logic        REF_CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic        STEP, DIR, HO, HOE, APOL, BPOL, SSV;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [7:0]  APOS, BPOS, ACUR;
    // bench state
    logic [7:0]  sp [9];
    logic [7:0]  cp [9];
    logic [9:0]  ph;
    logic [3:0]  md;
    logic        err, cus, edg, d;
    int          n_mismatch, compares, seed, i;

    msi_indexer #(.STSL_CYCLES(24'd1000)) i_msi_indexer (.REF_CLK(REF_CLK), .NRST(NRST),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .STEP(STEP), .DIR(DIR),
        .HOME_INDICATOR_LOW_O(HO), .HOME_INDICATOR_LOW_OE(HOE),
        .COIL_A_TABLE_POSITION(APOS), .COIL_A_POLARITY(APOL), .COIL_B_TABLE_POSITION(BPOS),
        .COIL_B_POLARITY(BPOL), .COIL_A_EXPECTED_CURRENT(ACUR), .STANDSTILL_SAVE(SSV));
    msi_step_ctrl i_msi_step_ctrl (.clk(REF_CLK), .step(STEP), .dir(DIR));

    // 50 MHz clock
    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    task wrap_up;
        if (n_mismatch == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk

    // apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
             output logic [31:0] r, output logic e);
        int k;
        @(posedge REF_CLK);
        {PSEL, PENABLE, PWRITE, PADDR, PWDATA} <= {2'b10, w, a, wd};
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        k = 0;
        do begin
            @(posedge REF_CLK);
            k++;
        end while (PREADY !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            wrap_up();
        end
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    function automatic logic [7:0] apos(input logic [9:0] p);
        return p[8] ? 8'hFF - p[7:0] : p[7:0];
    endfunction : apos

    // piecewise-linear lookup over nine points
    function automatic logic [7:0] cur_exp(input logic [7:0] x);
        int s, f, lo, hi;
        s = int'(x[7:5]);
        f = (x == 8'hFF) ? 32 : int'(x[4:0]);
        lo = cus ? cp[s] : sp[s];
        hi = cus ? cp[s+1] : sp[s+1];
        return 8'(lo + (((hi - lo) * f) >>> 5));
    endfunction : cur_exp

    task pos_chk;
        logic [7:0] a;
        a = apos(ph);
        chk({HOE, HO, APOL, BPOL, APOS, BPOS},
            {ph == HOME_PHASE, 1'b0, ~ph[9], ph[9] == ph[8], a, 8'hFF - a});
        chk(ACUR, cur_exp(a));
        apb(1'b0, ADDR_CURRENT, 32'h0, rd, err);
        chk(rd, {16'h0, cur_exp(8'hFF - a), cur_exp(a)});
        apb(1'b0, ADDR_POSITION, 32'h0, rd, err);
        chk(rd, {7'h0, ph[9] == ph[8], 8'hFF - a, 7'h0, ~ph[9], a});
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(rd[0], ph != HOME_PHASE);
    endtask : pos_chk

    // hang guard
    initial begin
        repeat (90000) @(posedge REF_CLK);
        n_mismatch++;
        wrap_up();
    end

    // main sequence
    initial begin
        {NRST, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
        seed = 92;
        cus = 1'b0;
        ph = HOME_PHASE;
        sp[0] = 8'h00;
        cp[0] = 8'h00;
        // reset profile is the built-in sine, needed before the first current check
        for (i = 1; i < 9; i++) begin
            sp[i] = SINE_POINTS[i-1];
        end
        repeat (5) @(posedge REF_CLK);
        NRST <= 1'b1;
        @(posedge REF_CLK);
        pos_chk();
        for (i = 1; i < 9; i++) begin
            sp[i] = SINE_POINTS[i-1];
            apb(1'b0, ADDR_PROF_BASE + 12'(4 * (i - 1)), 32'h0, rd, err);
            chk(rd, 32'(sp[i]));
            cp[i] = cp[i-1] + 8'($unsigned($random(seed)) % 32);
            apb(1'b1, ADDR_PROF_BASE + 12'(4 * (i - 1)), 32'(cp[i]), rd, err);
        end
        apb(1'b0, 12'h010, 32'h0, rd, err);
        chk({31'h0, err}, 32'h1);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, ADDR_CTRL, 32'(i) << CTRL_RES_LSB, rd, err);
            apb(1'b0, ADDR_CTRL, 32'h0, rd, err);
            chk(rd, 32'(i) << CTRL_RES_LSB);
        end
        // random modes, edges, profiles and directions
        for (i = 0; i < 24; i++) begin
            md = 4'($unsigned($random(seed)) % 9);
            edg = 1'($random(seed));
            cus = 1'($random(seed));
            d = 1'($random(seed));
            apb(1'b1, ADDR_CTRL, (32'(md) << CTRL_MODE_LSB) | (32'(edg) << CTRL_EDGE_BIT)
                | (32'(cus) << CTRL_CUSTOM_BIT), rd, err);
            i_msi_step_ctrl.pulse(d, 90);
            ph = d ? ph + ((10'h100 >> md) << edg) : ph - ((10'h100 >> md) << edg);
            repeat (8) @(posedge REF_CLK);
            pos_chk();
        end
        // interpolation in 1/16 mode with standstill saving on
        cus = 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h0000_0109, rd, err);
        for (i = 0; i < 4; i++) begin
            i_msi_step_ctrl.pulse(1'b1, 100);
            ph = ph + 10'd16;
        end
        chk({31'h0, APOS !== apos(ph)}, 32'h1);
        repeat (700) @(posedge REF_CLK);
        chk({31'h0, SSV}, 32'h0);
        pos_chk();
        repeat (300) @(posedge REF_CLK);
        chk({31'h0, SSV}, 32'h1);
        i_msi_step_ctrl.pulse(1'b1, 100);
        chk({31'h0, SSV}, 32'h0);
        wrap_up();
    end
endmodule : msi_indexer_tb
`default_nettype wire

// File: msi_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module msi_pin_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // pins
    input  wire logic [WIDTH-1:0] async_in,
    // filtered level and one-cycle edge pulses
    output var  logic [WIDTH-1:0] level,
    output var  logic [WIDTH-1:0] rise,
    output var  logic [WIDTH-1:0] fall
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] agree;
    logic [WIDTH-1:0] level_d;

    // a change counts once the second and third stages agree
    assign agree   = ~(s2_q ^ s3_q);
    assign level_d = (agree & s3_q) | (~agree & level);

    // three-stage chain, first stage feeds only the second
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            level <= '0;
            rise  <= '0;
            fall  <= '0;
        end else begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            level <= level_d;
            rise  <= level_d & ~level;
            fall  <= ~level_d & level;
        end
    end
endmodule : msi_pin_sync
`default_nettype wire

// File: msi_pkg.sv
`default_nettype none
package msi_pkg;
    // widths
    localparam int ADDR_W     = 12;
    localparam int DATA_W     = 32;
    localparam int PHASE_W    = 10;
    localparam int CNT_W      = 24;
    localparam int NUM_POINTS = 8;

    // phase of the 45 degree home state and finest step mode (log2 of 256)
    localparam logic [9:0] HOME_PHASE    = 10'h080;
    localparam logic [3:0] MODE_FINEST   = 4'h8;
    localparam logic [3:0] MODE_RST      = 4'h4;
    localparam logic [7:0] IDX_LAST      = 8'hFF;

    // register byte offsets
    localparam logic [11:0] ADDR_CTRL      = 12'h000;
    localparam logic [11:0] ADDR_STATUS    = 12'h004;
    localparam logic [11:0] ADDR_POSITION  = 12'h008;
    localparam logic [11:0] ADDR_CURRENT   = 12'h00C;
    localparam logic [11:0] ADDR_PROF_BASE = 12'h020;

    // control fields
    localparam int CTRL_INTERP_BIT = 0;
    localparam int CTRL_RES_LSB    = 1;
    localparam int CTRL_STSL_BIT   = 3;
    localparam int CTRL_CUSTOM_BIT = 4;
    localparam int CTRL_EDGE_BIT   = 5;
    localparam int CTRL_MODE_LSB   = 6;

    // status, position and current fields
    localparam int STAT_HOME_BIT  = 0;
    localparam int STAT_STSL_BIT  = 1;
    localparam int STAT_DIR_BIT   = 2;
    localparam int POS_A_LSB      = 0;
    localparam int POS_A_SIGN_BIT = 8;
    localparam int POS_B_LSB      = 16;
    localparam int POS_B_SIGN_BIT = 24;
    localparam int COIL_A_EXPECTED_CURRENT_LSB      = 0;
    localparam int CUR_B_LSB      = 8;

    // timing
    localparam int CLK_PERIOD_NS      = 20;
    localparam int STSL_DELAY_MS      = 100;
    localparam int STSL_DELAY_CYCLES  = STSL_DELAY_MS * 1000000 / CLK_PERIOD_NS;

    // built-in quarter sine at 11.25 degree points, index 0 is 11.25 degrees
    localparam logic [7:0][7:0] SINE_POINTS = {8'hFF, 8'hFA, 8'hEC, 8'hD4,
                                               8'hB4, 8'h8E, 8'h62, 8'h32};
endpackage : msi_pkg
`default_nettype wire

// File: msi_step_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module msi_step_ctrl (
    // clock
    input  wire logic clk,
    // step and direction pins
    output var  logic step,
    output var  logic dir
);
    // idle levels at time zero: step low, direction forward
    initial begin
        step = 1'b0;
        dir  = 1'b1;
    end

    // one step pulse, each half held h cycles; h of 84 or more keeps the rate within 300 kHz
    task automatic pulse(input logic d, input int h);
        @(posedge clk);
        dir <= d;
        repeat (h) @(posedge clk);
        step <= 1'b1;
        repeat (h) @(posedge clk);
        step <= 1'b0;
    endtask : pulse
endmodule : msi_step_ctrl
`default_nettype wire
